/* File: hdl/csctl_defines.svh */
// constants of the clock synthesizer control block
`ifndef CSCTL_DEFINES_SVH
`define CSCTL_DEFINES_SVH
`define CSCTL_ADDR_WR        8'hd2
`define CSCTL_ADDR_RD        8'hd3
`define CSCTL_NUM_CFG        6
`define CSCTL_BYTE_COUNT     8'h06
`define CSCTL_CFG0_RESET     8'h00
`define CSCTL_CFGN_RESET     8'hff
`define CSCTL_B0_TRI_BIT     0
`define CSCTL_B0_SPREAD_BIT  1
`define CSCTL_B0_DOWN_BIT    2
`define CSCTL_B0_WIDE_BIT    7
`define CSCTL_B0_SWSEL_BIT   3
`define CSCTL_B0_CODE_LSB    4
`define CSCTL_STOP_LAT_MAX   4
`endif

/* File: hdl/csctl_pkg.sv */
// types of the clock synthesizer control block
package csctl_pkg;
   typedef logic [7:0] csctl_byte_t;
   typedef enum logic [2:0] {
      CSCTL_IDLE = 3'b000,
      CSCTL_ADDR = 3'b001,
      CSCTL_WACK = 3'b011,
      CSCTL_WDAT = 3'b010,
      CSCTL_RDAT = 3'b110,
      CSCTL_RACK = 3'b111,
      CSCTL_SKIP = 3'b101
   } csctl_state_e;
endpackage

/* File: hdl/csctl_cfg_if.sv */
// carrier between serial slave and configuration store
`timescale 1ns/1ps
interface csctl_cfg_if;
   logic                 wr_en;
   logic [2:0]           wr_idx;
   logic [7:0]           wr_data;
   logic [2:0]           rd_idx;
   logic [7:0]           rd_data;
   logic [47:0]          cfg_flat;
   modport store  (input wr_en, input wr_idx, input wr_data, input rd_idx,
                   output rd_data, output cfg_flat);
   modport client (output wr_en, output wr_idx, output wr_data, output rd_idx,
                   input rd_data, input cfg_flat);
endinterface

/* File: hdl/csctl_cfg_mem.sv */
// six-byte configuration store with registered read port
`timescale 1ns/1ps
`include "csctl_defines.svh"
module csctl_cfg_mem (
   input  wire logic      clk,
   input  wire logic      rst_n,
   csctl_cfg_if.store     cfg
);
   logic [7:0] mem_q [`CSCTL_NUM_CFG];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mem_q[0] <= `CSCTL_CFG0_RESET;
         for (int i = 1; i < `CSCTL_NUM_CFG; i++) mem_q[i] <= `CSCTL_CFGN_RESET;
      end else if (cfg.wr_en && cfg.wr_idx < 3'(`CSCTL_NUM_CFG)) begin
         mem_q[cfg.wr_idx] <= cfg.wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) cfg.rd_data <= 8'h00;
      else if (cfg.rd_idx < 3'(`CSCTL_NUM_CFG)) cfg.rd_data <= mem_q[cfg.rd_idx];
      else cfg.rd_data <= 8'h00;
   end

   always_comb begin
      for (int i = 0; i < `CSCTL_NUM_CFG; i++) cfg.cfg_flat[i*8 +: 8] = mem_q[i];
   end
endmodule

/* File: hdl/csctl_top.sv */
// clock synthesizer strap, stop gating and serial configuration control
// Behaviour
// - frequency code picks processor, bus and graphics clock rates
// - memory clocks follow processor when source strap 1, graphics when 0
// - desktop strap: shared pins are memory clocks; mobile: stop inputs
// - processor-stop low in mobile holds processor and graphics clocks low
// - bus-stop low in mobile holds six stoppable bus clocks low
// - free bus, reference, 24/48 and memory clocks never stop
// - voltage strap 1 selects 2.5V processor buffers, 0 selects 3.3V
// - straps sampled at reset release, then strap pins driven; shared pins driven only in desktop
// - reference, 24 and 48 MHz outputs independent of code
// - write address D2 acknowledged, device is slave only
// - command and count bytes acknowledged and discarded
// - data bytes from byte 0 to 5 acknowledged, stop ends
// - block writes ascending, loading continues until stop
// - read address D3 acknowledged, device returns byte count
// - device sends bytes 0 to 5 after count
// - read-back shows current configuration latches
// - every transfer unit is eight bits
// - configuration bytes take defaults at power-on
// - byte 0 bit 3 chooses strap code or software code
// - byte 0 bit 1 enables spread spectrum
// - cleared enable bit holds its output low
// - processor clocks stop and restart within four cycles
`timescale 1ns/1ps
`include "csctl_defines.svh"
module csctl_top (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        proc_clk,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   input  wire logic        freq_code_bit0,
   input  wire logic        freq_code_bit1,
   input  wire logic        freq_code_bit2,
   input  wire logic        mem_clock_source_strap,
   input  wire logic        pin_function_strap,
   input  wire logic        proc_buffer_voltage_strap,
   input  wire logic        shared_pin17_in,
   input  wire logic        shared_pin18_in,
   output logic             straps_oe_n,
   output logic             shared_pins_oe_n,
   input  wire logic        proc_raw,
   input  wire logic        graphics_raw,
   input  wire logic        bus_raw,
   input  wire logic        mem_raw,
   input  wire logic        ref_raw,
   input  wire logic        clk24_raw,
   input  wire logic        clk48_raw,
   output logic [3:0]       processor_clock_out,
   output logic [1:0]       graphics_clock_out,
   output logic [5:0]       stoppable_bus_clock,
   output logic             free_running_bus_clock,
   output logic [11:0]      mem_clock_out,
   output logic [1:0]       ref_clock_out,
   output logic             clk24_out,
   output logic             clk48_out,
   output logic [2:0]       freq_code_q,
   output logic             mem_src_proc_q,
   output logic             desktop_mode_q,
   output logic             buffer_2v5_q,
   output logic             spread_enable,
   output logic             spread_wide,
   output logic             spread_down,
   output logic             tristate_all
);
   csctl_cfg_if cfg ();
   csctl_cfg_mem u_mem (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .cfg   (cfg)
   );

   // strap pins are board levels, asynchronous to ref_clk; no reset, so the level
   // held through reset has already reached the second stage at release
   logic [5:0] strap_s1_q, strap_s2_q;
   always_ff @(posedge ref_clk) begin
      strap_s1_q <= {proc_buffer_voltage_strap, pin_function_strap, mem_clock_source_strap,
                     freq_code_bit2, freq_code_bit1, freq_code_bit0};
      strap_s2_q <= strap_s1_q;
   end

   // strap latch at reset release; pins become outputs afterwards
   logic strap_done_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         strap_done_q   <= 1'b0;
         freq_code_q    <= 3'h0;
         mem_src_proc_q <= 1'b0;
         desktop_mode_q <= 1'b0;
         buffer_2v5_q   <= 1'b0;
      end else if (!strap_done_q) begin
         strap_done_q   <= 1'b1;
         freq_code_q    <= strap_s2_q[2:0];
         mem_src_proc_q <= strap_s2_q[3];
         desktop_mode_q <= strap_s2_q[4];
         buffer_2v5_q   <= strap_s2_q[5];
      end
   end
   assign straps_oe_n = ~strap_done_q;
   // shared pins driven only in desktop mode
   assign shared_pins_oe_n = ~(strap_done_q & desktop_mode_q);

   // effective code, spread controls, tristate
   logic [7:0] b0;
   assign b0            = cfg.cfg_flat[7:0];
   assign spread_enable = b0[`CSCTL_B0_SPREAD_BIT];
   assign spread_down   = b0[`CSCTL_B0_DOWN_BIT];
   assign spread_wide   = b0[`CSCTL_B0_WIDE_BIT];
   assign tristate_all  = b0[`CSCTL_B0_TRI_BIT];
   logic [2:0] code_sel;
   // code chooses rates for the synth outside this block
   assign code_sel = b0[`CSCTL_B0_SWSEL_BIT] ? b0[`CSCTL_B0_CODE_LSB +: 3] : freq_code_q;

   // ---------------- serial slave ----------------
   logic [1:0] scl_s_q, sda_s_q;
   logic       scl_q, sda_q;
   // two-flop synchronisers plus a delay stage; the second and third stages are read
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], scl_in};
         sda_s_q <= {sda_s_q[0], sda_in};
         scl_q   <= scl_s_q[1];
         sda_q   <= sda_s_q[1];
      end
   end
   logic scl_rise, scl_fall, start_ev, stop_ev;
   assign scl_rise = scl_s_q[1] & ~scl_q;
   assign scl_fall = ~scl_s_q[1] & scl_q;
   assign start_ev = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
   assign stop_ev  = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];

   csctl_pkg::csctl_state_e st_q;
   logic [7:0] sh_q;
   logic [3:0] bit_q;
   logic [3:0] byte_q;
   logic       rd_q, nack_q;

   // eight-bit units, then one acknowledge slot
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_q   <= csctl_pkg::CSCTL_IDLE;
         sh_q   <= 8'h00;
         bit_q  <= 4'h0;
         byte_q <= 4'h0;
         rd_q   <= 1'b0;
         nack_q <= 1'b0;
      end else if (start_ev) begin
         st_q  <= csctl_pkg::CSCTL_ADDR;
         bit_q <= 4'h0;
      end else if (stop_ev) begin
         st_q <= csctl_pkg::CSCTL_IDLE;
      end else begin
         unique case (st_q)
            csctl_pkg::CSCTL_IDLE, csctl_pkg::CSCTL_SKIP: ;
            csctl_pkg::CSCTL_ADDR, csctl_pkg::CSCTL_WDAT: begin
               if (scl_rise) begin
                  sh_q  <= {sh_q[6:0], sda_q};
                  bit_q <= bit_q + 4'h1;
               end else if (scl_fall && bit_q == 4'h8) begin
                  bit_q <= 4'h0;
                  if (st_q == csctl_pkg::CSCTL_ADDR) begin
                     if (sh_q == `CSCTL_ADDR_WR || sh_q == `CSCTL_ADDR_RD) begin
                        st_q   <= csctl_pkg::CSCTL_WACK;
                        rd_q   <= sh_q[0];
                        byte_q <= 4'h0;
                     end else begin
                        st_q <= csctl_pkg::CSCTL_SKIP;
                     end
                  end else begin
                     st_q <= csctl_pkg::CSCTL_WACK;
                  end
               end
            end
            csctl_pkg::CSCTL_WACK: begin
               // acknowledge slot ends at the next falling edge
               if (scl_fall) begin
                  if (rd_q) begin
                     st_q  <= csctl_pkg::CSCTL_RDAT;
                     sh_q  <= (byte_q == 4'h0) ? `CSCTL_BYTE_COUNT : cfg.rd_data;
                     bit_q <= 4'h0;
                  end else begin
                     st_q <= csctl_pkg::CSCTL_WDAT;
                  end
                  if (st_q == csctl_pkg::CSCTL_WACK && !rd_q) byte_q <= byte_q + 4'h1;
               end
            end
            csctl_pkg::CSCTL_RDAT: begin
               if (scl_fall) begin
                  sh_q  <= {sh_q[6:0], 1'b1};
                  bit_q <= bit_q + 4'h1;
                  if (bit_q == 4'h7) st_q <= csctl_pkg::CSCTL_RACK;
               end
            end
            csctl_pkg::CSCTL_RACK: begin
               // host nack ends the read
               if (scl_rise) nack_q <= sda_q;
               else if (scl_fall) begin
                  if (nack_q) st_q <= csctl_pkg::CSCTL_SKIP;
                  else begin
                     byte_q <= byte_q + 4'h1;
                     sh_q   <= cfg.rd_data;
                     bit_q  <= 4'h0;
                     st_q   <= csctl_pkg::CSCTL_RDAT;
                  end
               end
            end
            default: st_q <= csctl_pkg::CSCTL_IDLE;
         endcase
      end
   end

   // read index follows the byte being sent next
   assign cfg.rd_idx = rd_q ? ((st_q == csctl_pkg::CSCTL_RACK) ? 3'(byte_q) : 3'h0) : 3'h0;

   // bytes 1,2 discarded; later bytes load ascending until stop
   assign cfg.wr_en   = (st_q == csctl_pkg::CSCTL_WDAT) && !rd_q && scl_fall
                        && bit_q == 4'h8 && byte_q >= 4'h3;
   assign cfg.wr_idx  = 3'(byte_q - 4'h3);
   assign cfg.wr_data = sh_q;

   // open-drain data: low while acknowledging or sending a zero
   always_comb begin
      sda_out  = 1'b0;
      sda_oe_n = 1'b1;
      if (st_q == csctl_pkg::CSCTL_WACK) sda_oe_n = 1'b0;
      else if (st_q == csctl_pkg::CSCTL_RDAT && !sh_q[7]) sda_oe_n = 1'b0;
   end

   // ---------------- processor clock domain ----------------
   logic [1:0] ps_s_q, bs_s_q;
   logic       proc_run_q, bus_run_q, desk_p_q, desk_s_q;
   // synchronise stops on the processor clock, gate at its low phase
   always_ff @(posedge proc_clk) begin
      ps_s_q     <= {ps_s_q[0], shared_pin17_in};
      bs_s_q     <= {bs_s_q[0], shared_pin18_in};
      desk_s_q   <= desktop_mode_q;
      desk_p_q   <= desk_s_q;
   end
   // enables change on the falling edge, within four cycles
   always_ff @(negedge proc_clk) begin
      proc_run_q <= desk_p_q | ps_s_q[1];
      bus_run_q  <= desk_p_q | bs_s_q[1];
   end

   logic [7:0] b1, b2, b3, b4, b5;
   assign b1 = cfg.cfg_flat[15:8];
   assign b2 = cfg.cfg_flat[23:16];
   assign b3 = cfg.cfg_flat[31:24];
   assign b4 = cfg.cfg_flat[39:32];
   assign b5 = cfg.cfg_flat[47:40];
   logic mem_src;
   assign mem_src = mem_src_proc_q ? proc_raw : graphics_raw;

   // processor stop gates processor and graphics clocks
   assign processor_clock_out = {4{proc_raw & proc_run_q}} & b1[3:0];
   assign graphics_clock_out  = {2{graphics_raw & proc_run_q}} & {b5[4], b2[5]};
   // bus stop gates the six stoppable bus clocks
   assign stoppable_bus_clock = {6{bus_raw & bus_run_q}} & {1'b1, b2[4:0]};
   // free-running outputs ignore stops; fixed clocks
   assign free_running_bus_clock = bus_raw & b2[6];
   assign mem_clock_out = {12{mem_src}} & {b4[3] & desktop_mode_q, b4[2] & desktop_mode_q,
                                           b4[1:0], b3};
   assign ref_clock_out = {2{ref_raw}} & b5[1:0];
   assign clk24_out     = clk24_raw;
   assign clk48_out     = clk48_raw;

   // assertions
   property p_wr_ack;
      @(posedge ref_clk) disable iff (!rst_n)
      (st_q == csctl_pkg::CSCTL_WACK) |-> !sda_oe_n;
   endproperty
   a_wr_ack: assert property (p_wr_ack) else $error("ack not driven");
   property p_bad_addr;
      @(posedge ref_clk) disable iff (!rst_n)
      (st_q == csctl_pkg::CSCTL_SKIP) |-> sda_oe_n;
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("skip drives sda");
   property p_strap_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      strap_done_q |=> $stable(freq_code_q) && $stable(desktop_mode_q);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
   property p_cfg_wr;
      @(posedge ref_clk) disable iff (!rst_n)
      cfg.wr_en |-> byte_q >= 4'h3 && !rd_q;
   endproperty
   a_cfg_wr: assert property (p_cfg_wr) else $error("bad write");
   property p_code;
      @(posedge ref_clk) disable iff (!rst_n)
      !b0[3] |-> code_sel == freq_code_q;
   endproperty
   a_code: assert property (p_code) else $error("code source");
   property p_stop;
      @(posedge proc_clk) $fell(ps_s_q[1]) && desk_p_q == 1'b0 |-> ##[0:3] !proc_run_q;
   endproperty
   a_stop: assert property (p_stop) else $error("stop too slow");
   property p_restart;
      @(posedge proc_clk) $rose(ps_s_q[1]) && desk_p_q == 1'b0 |-> ##[0:3] proc_run_q;
   endproperty
   a_restart: assert property (p_restart) else $error("restart too slow");
   property p_pins;
      @(posedge ref_clk) disable iff (!rst_n)
      !desktop_mode_q |-> shared_pins_oe_n;
   endproperty
   a_pins: assert property (p_pins) else $error("pins driven in mobile");
   property p_spread;
      @(posedge ref_clk) disable iff (!rst_n)
      cfg.wr_en && cfg.wr_idx == 3'h0
      |=> spread_enable == $past(cfg.wr_data[`CSCTL_B0_SPREAD_BIT]);
   endproperty
   a_spread: assert property (p_spread) else $error("spread");
   c_write: cover property (@(posedge ref_clk) disable iff (!rst_n) cfg.wr_en);
   c_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
      st_q == csctl_pkg::CSCTL_RACK);
   c_skip: cover property (@(posedge ref_clk) disable iff (!rst_n)
      st_q == csctl_pkg::CSCTL_SKIP);
endmodule

/* File: verif/csctl_host.sv */
// two-wire serial host model for the configuration port
`timescale 1ns/1ps
module csctl_host (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   localparam int QTR = 25;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic start();
      sda_low <= 1'b0;
      scl <= 1'b1;
      wt(2 * QTR);
      sda_low <= 1'b1;
      wt(QTR);
      scl <= 1'b0;
      wt(QTR);
   endtask
   task automatic stop();
      sda_low <= 1'b1;
      wt(QTR);
      scl <= 1'b1;
      wt(QTR);
      sda_low <= 1'b0;
      wt(2 * QTR);
   endtask
   // sda sampled mid high phase, data changes only while scl low
   task automatic bit_io(input logic b, output logic s);
      sda_low <= !b;
      wt(QTR);
      scl <= 1'b1;
      wt(QTR);
      s = sda;
      wt(QTR);
      scl <= 1'b0;
      wt(QTR);
   endtask
   // eight bits msb first, then the ack slot
   task automatic xfer(input logic [7:0] tx, input logic ack_in,
                       output logic [7:0] rx, output logic ack_out);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ack_in, ack_out);
   endtask
endmodule

/* File: verif/tb_csctl_top.sv */
// self-checking bench of the clock synthesizer control block
`timescale 1ns/1ps
`include "csctl_defines.svh"
module tb_csctl_top;
   logic        ref_clk = 1'b0;
   logic        proc_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [5:0]  strap = 6'h00;
   logic        stp_p_n = 1'b1;
   logic        stp_b_n = 1'b1;
   logic        scl;
   logic        sda_low;
   logic        sda;
   logic        gfx_clk;
   logic [5:0]  strap_lat = 6'h00;
   logic        sda_out, sda_oe_n, straps_oe_n, sh_oe_n, fbus, c24, c48;
   logic        msrc, desk, b25, spr_en, spr_wide, spr_down, tri_all;
   logic [3:0]  pclk;
   logic [1:0]  gclk, rclk;
   logic [5:0]  bclk;
   logic [11:0] mclk;
   logic [2:0]  fcode;
   logic [7:0]  cfg [6];
   logic [7:0]  pay [8];
   int          num_errors = 0;
   int          n_tests = 0;
   // main clock 10 MHz
   always #50 ref_clk = ~ref_clk;
   // processor clock 12 ns, phase offset keeps edges apart
   initial begin
      #3.7;
      forever #6 proc_clk = ~proc_clk;
   end
   // pull-up on the data line, either party may pull low
   assign sda = !(sda_low || !sda_oe_n);
   // graphics source in antiphase, so the memory source choice is visible
   assign gfx_clk = ~proc_clk;
   csctl_host host (.clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
   csctl_top dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .proc_clk(proc_clk), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .freq_code_bit0(strap[0]), .freq_code_bit1(strap[1]), .freq_code_bit2(strap[2]),
      .mem_clock_source_strap(strap[3]), .pin_function_strap(strap[4]),
      .proc_buffer_voltage_strap(strap[5]), .shared_pin17_in(stp_p_n),
      .shared_pin18_in(stp_b_n), .straps_oe_n(straps_oe_n), .shared_pins_oe_n(sh_oe_n),
      .proc_raw(proc_clk), .graphics_raw(gfx_clk), .bus_raw(proc_clk),
      .mem_raw(proc_clk), .ref_raw(proc_clk), .clk24_raw(proc_clk), .clk48_raw(proc_clk),
      .processor_clock_out(pclk), .graphics_clock_out(gclk), .stoppable_bus_clock(bclk),
      .free_running_bus_clock(fbus), .mem_clock_out(mclk), .ref_clock_out(rclk),
      .clk24_out(c24), .clk48_out(c48), .freq_code_q(fcode), .mem_src_proc_q(msrc),
      .desktop_mode_q(desk), .buffer_2v5_q(b25), .spread_enable(spr_en),
      .spread_wide(spr_wide), .spread_down(spr_down), .tristate_all(tri_all));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // reset, then turn the strap inputs round to prove they were latched
   task automatic do_reset(input logic [5:0] s);
      strap <= s;
      strap_lat = s;
      rst_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("straps oe in reset", 1, straps_oe_n);
      @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      strap <= ~s;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("straps oe", 0, straps_oe_n);
      chk("straps", s, {b25, desk, msrc, fcode});
      chk("shared oe", !s[4], sh_oe_n);
      cfg = '{`CSCTL_CFG0_RESET, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
      @(posedge ref_clk);
   endtask
   // block write; pay holds command, count, then data bytes
   task automatic wr(input logic [7:0] adr, input int n, input logic ok);
      logic [7:0] r;
      logic       a;
      host.start();
      host.xfer(adr, 1'b1, r, a);
      chk("addr ack", !ok, a);
      for (int i = 0; i < n; i++) begin
         host.xfer(pay[i], 1'b1, r, a);
         chk("byte ack", !ok, a);
         if (ok && i > 1) cfg[i - 2] = pay[i];
      end
      host.stop();
   endtask
   // block read, nack on the last byte ends it
   task automatic rd();
      logic [7:0] r;
      logic       a;
      host.start();
      host.xfer(`CSCTL_ADDR_RD, 1'b1, r, a);
      chk("read ack", 0, a);
      host.xfer(8'hff, 1'b0, r, a);
      chk("byte count", `CSCTL_BYTE_COUNT, r);
      for (int i = 0; i < 6; i++) begin
         host.xfer(8'hff, i == 5, r, a);
         chk("read byte", cfg[i], r);
      end
      host.stop();
   endtask
   // gated outputs against the source clock, enables and stops
   task automatic clk_chk(input logic ps, input logic bs);
      logic p, g, m;
      repeat (3) begin
         @(negedge ref_clk);
         p = proc_clk;
         g = gfx_clk;
         m = strap_lat[3] ? p : g;
         chk("proc", ps ? 4'h0 : {4{p}} & cfg[1][3:0], pclk);
         chk("gfx", ps ? 2'h0 : {cfg[5][4], cfg[2][5]} & {2{g}}, gclk);
         chk("bus", bs ? 6'h00 : {1'b1, cfg[2][4:0]} & {6{p}}, bclk);
         chk("free", {cfg[2][6] & p, cfg[5][1:0] & {2{p}}, p, p},
             {fbus, rclk, c24, c48});
         chk("mem", {cfg[4][1:0], cfg[3]} & {10{m}}, mclk[9:0]);
         chk("mem hi", strap_lat[4] ? cfg[4][3:2] & {2{m}} : 2'h0, mclk[11:10]);
      end
      @(posedge ref_clk);
   endtask
   initial begin
      do_reset(6'b101101);
      rd();
      clk_chk(1'b0, 1'b0);
      stp_p_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      clk_chk(1'b1, 1'b0);
      stp_p_n <= 1'b1;
      stp_b_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      clk_chk(1'b0, 1'b1);
      stp_b_n <= 1'b1;
      $display("test defaults and stops done");
      pay = '{8'h5a, 8'h3c, 8'h8e, 8'hf5, 8'hdf, 8'h7e, 8'hfc, 8'hef};
      wr(`CSCTL_ADDR_WR, 8, 1'b1);
      chk("spread", 4'he, {spr_wide, spr_down, spr_en, tri_all});
      rd();
      repeat (2) @(posedge ref_clk);
      clk_chk(1'b0, 1'b0);
      $display("test full write done");
      pay = '{8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00};
      wr(`CSCTL_ADDR_WR, 4, 1'b1);
      chk("spread off", 4'h0, {spr_wide, spr_down, spr_en, tri_all});
      rd();
      $display("test partial write done");
      wr(8'ha0, 8, 1'b0);
      wr(`CSCTL_ADDR_RD - 8'h02, 8, 1'b0);
      rd();
      $display("test foreign address done");
      do_reset(6'b010010);
      rd();
      stp_p_n <= 1'b0;
      stp_b_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      clk_chk(1'b0, 1'b0);
      $display("test desktop done");
      wrap_up();
   end
endmodule
